// ### hdl/obm_params.svh
// constants for the boot mirror: otp geometry, header offsets, ram base
// assumes inclusion by the package and by every design file that needs it
`ifndef OBM_PARAMS_SVH
`define OBM_PARAMS_SVH
`define OBM_OTP_WORDS      8192
`define OBM_OTP_AW         13
`define OBM_RAM_AW         14
`define OBM_DATA_W         32
`define OBM_VEC_WORDS      64
`define OBM_HDR_LEN_BYTE   16'h7FF8
`define OBM_HDR_DBG_BYTE   16'h7FFC
`define OBM_DBG_ON         8'h00
`define OBM_DBG_OFF        8'hAA
`define OBM_RAM_BASE       14'h0000
`define OBM_OTP_FIRST      13'h0000
`define OBM_RC_HZ          16000000
`define OBM_SYS_HZ         40000000
`endif

// ### hdl/obm_pkg.sv
// types for the otp boot mirror
// assumes obm_params.svh on the include path
`include "obm_params.svh"
package obm_pkg;
  typedef enum logic [2:0] {
    OBM_IDLE, OBM_RD_DBG, OBM_RD_LEN, OBM_COPY, OBM_DRAIN, OBM_DONE
  } obm_state_e;
  typedef struct packed {
    logic                      en;
    logic [`OBM_RAM_AW-1:0]    addr;
    logic [`OBM_DATA_W-1:0]    data;
  } obm_ram_wr_s;
endpackage

// ### hdl/obm_rc_tick.sv
// fractional divider standing in for the fast rc oscillator
// assumes one system clock; emits one-cycle enable pulses at num/den rate
`timescale 1ns/10ps
`include "obm_params.svh"
module obm_rc_tick #(
  parameter int NUM = `OBM_RC_HZ,
  parameter int DEN = `OBM_SYS_HZ
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  output logic      tick
);
  // an accumulator step above the modulus would need two ticks per cycle
  if (NUM < 1 || NUM > DEN) begin : g_bad_rate
    $error("obm_rc_tick: need 1 <= NUM <= DEN");
  end
  logic [31:0] acc;
  logic [31:0] next_acc;
  logic        next_tick;
  always_comb begin
    next_tick = 1'b0;
    next_acc  = acc + 32'(NUM);
    if (next_acc >= 32'(DEN)) begin
      next_acc  = next_acc - 32'(DEN);
      next_tick = 1'b1;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc  <= 32'h0000_0000;
      tick <= 1'b0;
    end else begin
      acc  <= next_acc;
      tick <= next_tick;
    end
  end
endmodule

// ### hdl/obm_mirror.sv
// otp boot mirror: copies the boot image from otp into system ram
// assumes a synchronous otp read port with one cycle of latency
// Behaviour
// [R1] every power-up or wake-up copies the boot image to ram without the cpu; here only wake starts a copy, reset alone releases the cpu
// [R2] copy paced by the fast rc oscillator while the fast crystal settles
// [R3] development mode maps address zero to the code memory and resets cpu
// [R4] otp is 8192 words of 32 bits, addressed in whole words
// [R5] image starts at word zero with 64 vectors, landing at cpu address zero
// [R6] programmer leaves one blank word between code and first patch area
// [R7] after copy the cpu starts via reset release or a jump into ram
// [R8] words copied come from the header length word
// [R9] header debug flag 0x00 keeps debug enabled, 0xAA disables it
// [R10] copy ascends from otp word zero to ram base; cpu held in reset
`timescale 1ns/10ps
`include "obm_params.svh"
module obm_mirror #(
  parameter int OTP_WORDS = `OBM_OTP_WORDS,
  parameter int VEC_WORDS = `OBM_VEC_WORDS
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  input  wire logic                     wake,
  input  wire logic                     dev_mode,
  input  wire logic                     dev_sw_reset,
  input  wire logic                     fast_crystal_osc_ok,
  input  wire logic [`OBM_DATA_W-1:0]   otp_rdata,
  output logic                          otp_rd,
  output logic [`OBM_OTP_AW-1:0]        otp_addr,
  output obm_pkg::obm_ram_wr_s          ram_wr,
  output logic                          cpu_rst_n,
  output logic                          remap_to_ram,
  output logic                          debug_en,
  output logic                          busy,
  output logic                          len_err
);
  // header offsets are fixed word positions, so the array size is too
  if (OTP_WORDS != `OBM_OTP_WORDS) begin : g_bad_otp
    $error("obm_mirror: otp size fixed");
  end
  if (VEC_WORDS < 1 || VEC_WORDS > OTP_WORDS) begin : g_bad_vec
    $error("obm_mirror: vec");
  end

  // ************************************************************
  // slow pacing
  // ************************************************************
  logic rc_tick;
  logic step;
  obm_rc_tick u_tick (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .tick    (rc_tick)
  );
  // rc pacing until the crystal has settled, then full rate
  assign step = rc_tick | fast_crystal_osc_ok; // R2

  // ************************************************************
  // sequencer
  // ************************************************************
  obm_pkg::obm_state_e           state, next_state;
  logic [`OBM_OTP_AW:0]          len, next_len;
  logic [`OBM_OTP_AW:0]          cnt, next_cnt;
  logic                          rd_q, next_rd_q;
  logic                          next_otp_rd;
  logic [`OBM_OTP_AW-1:0]        next_otp_addr;
  obm_pkg::obm_ram_wr_s          next_ram_wr;
  logic                          next_cpu_rst_n;
  logic                          next_remap;
  logic                          next_debug_en;
  logic                          next_busy;
  logic                          next_len_err;
  logic [`OBM_OTP_AW-1:0]        wr_idx, next_wr_idx;
  logic [`OBM_OTP_AW:0]          hdr_len;

  assign hdr_len = (otp_rdata > 32'(OTP_WORDS)) ? (`OBM_OTP_AW+1)'(OTP_WORDS)
                 : (`OBM_OTP_AW+1)'(otp_rdata);

  always_comb begin
    next_state     = state;
    next_len       = len;
    next_cnt       = cnt;
    next_rd_q      = 1'b0;
    next_wr_idx    = wr_idx;
    next_otp_rd    = 1'b0;
    next_otp_addr  = otp_addr;
    next_ram_wr    = '0;
    next_cpu_rst_n = cpu_rst_n;
    next_remap     = remap_to_ram;
    next_debug_en  = debug_en;
    next_busy      = busy;
    next_len_err   = len_err;
    unique case (state)
      obm_pkg::OBM_IDLE: begin
        if (wake) begin // R1
          next_cpu_rst_n = 1'b0; // R10
          next_busy      = 1'b1;
          next_len_err   = 1'b0;
          next_state     = obm_pkg::OBM_RD_DBG;
          next_otp_rd    = 1'b1;
          next_otp_addr  = `OBM_OTP_AW'(`OBM_HDR_DBG_BYTE >> 2); // R4
        end else if (dev_mode && dev_sw_reset) begin
          // ram already holds downloaded code; hold cpu reset while dev_sw_reset stays high
          next_remap     = 1'b1; // R3
          next_cpu_rst_n = 1'b0; // R3
        end else begin
          next_cpu_rst_n = 1'b1; // R7
        end
      end
      obm_pkg::OBM_RD_DBG: begin
        if (!rd_q) begin
          // flag word still in flight; fetch the length word meanwhile
          next_otp_rd   = 1'b1;
          next_otp_addr = `OBM_OTP_AW'(`OBM_HDR_LEN_BYTE >> 2);
          next_rd_q     = 1'b1;
        end else begin
          next_otp_addr = `OBM_OTP_FIRST;
          next_state    = obm_pkg::OBM_RD_LEN;
          // only 0xAA closes the port; other codes leave it open
          next_debug_en = (otp_rdata[7:0] != `OBM_DBG_OFF); // R9
        end
      end
      obm_pkg::OBM_RD_LEN: begin
        next_len      = hdr_len; // R8
        next_len_err  = (otp_rdata > 32'(OTP_WORDS));
        next_cnt      = '0;
        next_otp_addr = `OBM_OTP_FIRST; // R10
        next_state    = (hdr_len == '0) ? obm_pkg::OBM_DONE
                                        : obm_pkg::OBM_COPY;
      end
      obm_pkg::OBM_COPY: begin
        // otp data stands only in the cycle after its strobe
        next_rd_q   = otp_rd;
        next_wr_idx = otp_addr;
        if (rd_q) begin
          next_ram_wr.en   = 1'b1;
          next_ram_wr.addr = `OBM_RAM_BASE + `OBM_RAM_AW'(wr_idx); // R5
          next_ram_wr.data = otp_rdata;
        end
        if (step && cnt < len) begin
          next_otp_rd   = 1'b1;
          next_otp_addr = `OBM_OTP_AW'(cnt); // R10
          next_cnt      = cnt + 1'b1;
        end else if (cnt == len) begin
          next_state = obm_pkg::OBM_DRAIN;
        end
      end
      obm_pkg::OBM_DRAIN: begin
        if (rd_q) begin
          next_ram_wr.en   = 1'b1;
          next_ram_wr.addr = `OBM_RAM_BASE + `OBM_RAM_AW'(wr_idx);
          next_ram_wr.data = otp_rdata;
        end
        next_state = obm_pkg::OBM_DONE;
      end
      obm_pkg::OBM_DONE: begin
        next_remap     = 1'b1; // R5
        next_busy      = 1'b0;
        next_cpu_rst_n = 1'b1; // R7
        next_state     = obm_pkg::OBM_IDLE;
      end
      default: next_state = obm_pkg::OBM_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state        <= obm_pkg::OBM_IDLE;
      len          <= '0;
      cnt          <= '0;
      rd_q         <= 1'b0;
      wr_idx       <= '0;
      otp_rd       <= 1'b0;
      otp_addr     <= '0;
      ram_wr       <= '0;
      cpu_rst_n    <= 1'b0;
      remap_to_ram <= 1'b0;
      debug_en     <= 1'b1;
      busy         <= 1'b0;
      len_err      <= 1'b0;
    end else begin
      state        <= next_state;
      len          <= next_len;
      cnt          <= next_cnt;
      rd_q         <= next_rd_q;
      wr_idx       <= next_wr_idx;
      otp_rd       <= next_otp_rd;
      otp_addr     <= next_otp_addr;
      ram_wr       <= next_ram_wr;
      cpu_rst_n    <= next_cpu_rst_n;
      remap_to_ram <= next_remap;
      debug_en     <= next_debug_en;
      busy         <= next_busy;
      len_err      <= next_len_err;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  property p_wake_holds_cpu;
    @(posedge sys_clk) disable iff (!rst_n)
      (state == obm_pkg::OBM_IDLE && wake) |=> (!cpu_rst_n && busy);
  endproperty
  a_wake_holds_cpu: assert property (p_wake_holds_cpu) // R1
    else $error("wake did not start a held copy");
  property p_reset_while_busy;
    @(posedge sys_clk) disable iff (!rst_n) busy |-> !cpu_rst_n;
  endproperty
  a_reset_while_busy: assert property (p_reset_while_busy) // R10
    else $error("cpu released during copy");
  property p_pace;
    @(posedge sys_clk) disable iff (!rst_n)
      (state == obm_pkg::OBM_COPY && !step) |=> !otp_rd;
  endproperty
  a_pace: assert property (p_pace) // R2
    else $error("otp read without pacing step");
  property p_dev_remap;
    @(posedge sys_clk) disable iff (!rst_n)
      (state == obm_pkg::OBM_IDLE && !wake && dev_mode && dev_sw_reset)
      |=> (remap_to_ram && !cpu_rst_n);
  endproperty
  a_dev_remap: assert property (p_dev_remap) // R3
    else $error("dev reset did not remap");
  property p_word_addr;
    @(posedge sys_clk) disable iff (!rst_n)
      ram_wr.en |-> ram_wr.addr == `OBM_RAM_AW'($past(otp_addr, 2));
  endproperty
  a_word_addr: assert property (p_word_addr) // R4
    else $error("ram address does not follow otp word");
  property p_data;
    @(posedge sys_clk) disable iff (!rst_n)
      ram_wr.en |-> ram_wr.data == $past(otp_rdata);
  endproperty
  a_data: assert property (p_data) // R5
    else $error("ram data differs from otp word");
  property p_first;
    @(posedge sys_clk) disable iff (!rst_n)
      (state == obm_pkg::OBM_RD_LEN) |=> otp_addr == `OBM_OTP_FIRST;
  endproperty
  a_first: assert property (p_first) // R10
    else $error("copy does not start at word zero");
  property p_len;
    @(posedge sys_clk) disable iff (!rst_n)
      (state == obm_pkg::OBM_DRAIN) |-> cnt == len;
  endproperty
  a_len: assert property (p_len) // R8
    else $error("copied count differs from header length");
  property p_dbg;
    @(posedge sys_clk) disable iff (!rst_n)
      (state == obm_pkg::OBM_RD_DBG && rd_q
       && otp_rdata[7:0] == `OBM_DBG_OFF)
      |=> !debug_en;
  endproperty
  a_dbg: assert property (p_dbg) // R9
    else $error("debug flag 0xAA did not disable");
  property p_release;
    @(posedge sys_clk) disable iff (!rst_n)
      (state == obm_pkg::OBM_DONE) |=> (cpu_rst_n && remap_to_ram && !busy);
  endproperty
  a_release: assert property (p_release) // R7
    else $error("cpu not released after copy");
  c_copy: cover property (@(posedge sys_clk) disable iff (!rst_n)
    state == obm_pkg::OBM_DONE && len > 1);
  c_dbg_off: cover property (@(posedge sys_clk) disable iff (!rst_n)
    !debug_en);
  c_dev: cover property (@(posedge sys_clk) disable iff (!rst_n)
    dev_mode && dev_sw_reset && state == obm_pkg::OBM_IDLE);
endmodule

// ### tb/obm_otp_model.sv
// otp array model: synchronous read port with one cycle of latency
// assumes the bench preloads mem by hierarchical reference
`timescale 1ns/10ps
`include "obm_params.svh"
module obm_otp_model (
  input  wire logic                   sys_clk,
  input  wire logic                   otp_rd,
  input  wire logic [`OBM_OTP_AW-1:0] otp_addr,
  output logic      [`OBM_DATA_W-1:0] otp_rdata
);
  logic [`OBM_DATA_W-1:0] mem [`OBM_OTP_WORDS];
  initial otp_rdata = '0;
  // data is valid one cycle only; it toggles so a late sample shows up
  always @(posedge sys_clk) begin
    if (otp_rd) begin
      otp_rdata <= mem[otp_addr];
    end else begin
      otp_rdata <= ~otp_rdata;
    end
  end
endmodule

// ### tb/tb_otp_boot_mirror.sv
// bench for the boot mirror: otp model, write scoreboard, cpu reset checks
// assumes the mirror with its default parameters and one 40 MHz clock
`timescale 1ns/10ps
`include "obm_params.svh"
module tb_otp_boot_mirror;
  logic                   sys_clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   wake = 1'b0;
  logic                   dev_mode = 1'b0;
  logic                   dev_sw_reset = 1'b0;
  logic                   fast_crystal_osc_ok = 1'b1;
  logic [`OBM_DATA_W-1:0] otp_rdata;
  logic                   otp_rd;
  logic [`OBM_OTP_AW-1:0] otp_addr;
  obm_pkg::obm_ram_wr_s   ram_wr;
  logic                   cpu_rst_n;
  logic                   remap_to_ram;
  logic                   debug_en;
  logic                   busy;
  logic                   len_err;
  int                     miscompares = 0;
  int                     n_compared = 0;
  int                     cycles = 0;
  obm_pkg::obm_ram_wr_s   exp_q [$];

  always #12.5 sys_clk = ~sys_clk;

  obm_mirror obm_mirror_i (.sys_clk(sys_clk), .rst_n(rst_n), .wake(wake),
    .dev_mode(dev_mode), .dev_sw_reset(dev_sw_reset),
    .fast_crystal_osc_ok(fast_crystal_osc_ok), .otp_rdata(otp_rdata),
    .otp_rd(otp_rd), .otp_addr(otp_addr), .ram_wr(ram_wr),
    .cpu_rst_n(cpu_rst_n), .remap_to_ram(remap_to_ram),
    .debug_en(debug_en), .busy(busy), .len_err(len_err));
  obm_otp_model obm_otp_model_i (.sys_clk(sys_clk), .otp_rd(otp_rd),
    .otp_addr(otp_addr), .otp_rdata(otp_rdata));

  // ****************************************
  // checking tasks
  // ****************************************
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cmp_bit(input logic got, input logic exp, input string s);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s", $time, s);
    end
  endtask

  task automatic cmp_wr(input obm_pkg::obm_ram_wr_s got);
    obm_pkg::obm_ram_wr_s e;
    n_compared++;
    if (exp_q.size() == 0) begin
      miscompares++;
      $display("MISMATCH %0t unexpected ram write", $time);
    end else begin
      e = exp_q.pop_front();
      if (got.addr !== e.addr || got.data !== e.data) begin
        miscompares++;
        $display("MISMATCH %0t ram write %h %h", $time, got.addr, got.data);
      end
    end
  endtask

  // ****************************************
  // boot sequence with expected writes
  // ****************************************
  task automatic boot(input int len, input logic [7:0] flag, input logic xok);
    int n;
    int t;
    obm_pkg::obm_ram_wr_s e;
    n = (len > `OBM_OTP_WORDS) ? `OBM_OTP_WORDS : len;
    for (int i = 0; i < `OBM_OTP_WORDS; i++) begin
      obm_otp_model_i.mem[i] = $urandom;
    end
    if (len < `OBM_OTP_WORDS) begin
      obm_otp_model_i.mem[len] = '0;
    end
    obm_otp_model_i.mem[`OBM_HDR_DBG_BYTE >> 2] = {4{flag}};
    obm_otp_model_i.mem[`OBM_HDR_LEN_BYTE >> 2] = len;
    e.en = 1'b1;
    for (int i = 0; i < n; i++) begin
      e.addr = `OBM_RAM_BASE + 14'(i);
      e.data = obm_otp_model_i.mem[i];
      exp_q.push_back(e);
    end
    fast_crystal_osc_ok = xok;
    wake = 1'b1;
    @(negedge sys_clk);
    wake = 1'b0;
    cmp_bit(busy, 1'b1, "copy not started");
    t = 0;
    // a second wake in mid copy must not restart it
    while (busy === 1'b1 && t < 20000) begin
      wake = (t == 20);
      @(negedge sys_clk);
      t++;
    end
    wake = 1'b0;
    cmp_bit(busy, 1'b0, "copy hung");
    cmp_bit(cpu_rst_n, 1'b1, "cpu not started");
    cmp_bit(remap_to_ram, 1'b1, "no remap after copy");
    cmp_bit(debug_en, flag != 8'hAA, "debug flag");
    cmp_bit(len_err, len > `OBM_OTP_WORDS, "length error");
    if (!xok) begin
      cmp_bit(t >= 2 * n, 1'b1, "copy faster than rc");
    end
    repeat (3) @(negedge sys_clk);
    cmp_bit(exp_q.size() == 0, 1'b1, "missing ram writes");
  endtask

  // ****************************************
  // monitor, timeout and main sequence
  // ****************************************
  always @(negedge sys_clk) begin
    if (rst_n === 1'b1 && ram_wr.en === 1'b1) begin
      cmp_wr(ram_wr);
    end
    if (busy === 1'b1) begin
      cmp_bit(cpu_rst_n, 1'b0, "cpu released during copy");
    end
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      $display("MISMATCH %0t timeout", $time);
      test_done();
    end
  end

  initial begin
    void'($urandom(8616));
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    cmp_bit(debug_en, 1'b1, "debug reset value");
    @(negedge sys_clk);
    cmp_bit(cpu_rst_n, 1'b1, "cpu not out of reset");
    boot(100, 8'hAA, 1'b1);
    boot(100, 8'h00, 1'b0);
    boot(0, 8'h55, 1'b1);
    boot(int'($urandom_range(200, 65)), 8'hAA, 1'b1);
    boot(`OBM_OTP_WORDS + 1, 8'h00, 1'b1);
    // development mode right after a fresh reset
    rst_n = 1'b0;
    @(negedge sys_clk);
    cmp_bit(remap_to_ram, 1'b0, "remap not cleared");
    rst_n = 1'b1;
    dev_mode = 1'b1;
    dev_sw_reset = 1'b1;
    @(negedge sys_clk);
    cmp_bit(remap_to_ram, 1'b1, "dev remap");
    cmp_bit(cpu_rst_n, 1'b0, "dev cpu reset");
    dev_sw_reset = 1'b0;
    @(negedge sys_clk);
    cmp_bit(cpu_rst_n, 1'b1, "dev cpu release");
    test_done();
  end
endmodule
